// ### dv/dma_model.sv
// dma side model feeding fifo occupancy and idle status
`timescale 1ns/1ps
module dma_model (
  input wire logic core_clk,
  output logic [7:0] rx_cells,
  output mac_fifo_pkg::tx_fifo_state_t tx_state,
  output logic rx_dma_idle,
  output logic tx_dma_idle
);
  initial begin
    rx_cells = 8'h00;
    tx_state = '0;
    rx_dma_idle = 1'b1;
    tx_dma_idle = 1'b1;
  end
  task automatic load(input logic [7:0] r, input logic [7:0] t, input logic d);
    @(posedge core_clk);
    rx_cells <= r;
    tx_state <= '{cells: t, pkt_done: d};
  endtask
  // rx and tx engines may be busy independently or together
  task automatic busy(input logic rb, input logic tb);
    @(posedge core_clk);
    rx_dma_idle <= !rb;
    tx_dma_idle <= !tb;
  endtask
endmodule

// ### dv/mac_fifo_ctrl_chk.sv
// port checker for the fifo threshold and soft reset block
`timescale 1ns/1ps
module mac_fifo_ctrl_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic rx_flow_en,
  input wire logic [7:0] rx_cells,
  input wire mac_fifo_pkg::tx_fifo_state_t tx_state,
  input wire logic rx_dma_idle,
  input wire logic tx_dma_idle,
  input wire logic rx_flow_active,
  input wire logic tx_start_ok,
  input wire logic mac_soft_rst
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence rst_wr;
    psel && penable && pwrite && paddr == 12'h008 && pwdata[0];
  endsequence
  a_flow_off: assert property (!rx_flow_en |=> !rx_flow_active)
    else $error("flow active while disabled");
  a_flow_full: assert property (rx_flow_en && rx_cells >= 8'h7f |=> rx_flow_active)
    else $error("flow missed at max occupancy");
  a_short_pkt: assert property (tx_state.pkt_done |=> tx_start_ok)
    else $error("whole packet not started");
  a_tx_empty: assert property (tx_state == 9'h000 |=> !tx_start_ok)
    else $error("start with empty fifo");
  a_depth_read: assert property (psel && !penable && !pwrite && paddr == 12'h004
    |=> prdata == 32'h1844_0203) else $error("depth word wrong");
  a_rst_idle: assert property (mac_soft_rst |-> $past(rx_dma_idle && tx_dma_idle))
    else $error("soft reset while dma busy");
  a_rst_pulse: assert property (mac_soft_rst |=> !mac_soft_rst)
    else $error("soft reset pulse too long");
  a_rst_fires: assert property (rst_wr ##1 (rx_dma_idle && tx_dma_idle)
    |-> ##[0:1] mac_soft_rst) else $error("soft reset not executed");
  a_unmapped_err: assert property (psel && penable && paddr > 12'h008 |-> pslverr)
    else $error("unmapped access without error");
  c_flow: cover property (rx_flow_en ##1 rx_flow_active);
  c_start: cover property (!tx_state.pkt_done ##1 tx_start_ok);
  c_soft: cover property (mac_soft_rst);
endmodule
bind mac_fifo_ctrl mac_fifo_ctrl_chk chk_u (.*);

// ### dv/mac_fifo_ctrl_test.sv
// self-checking bench for the fifo threshold and soft reset block
`timescale 1ns/1ps
module mac_fifo_ctrl_test;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rx_flow_en = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, rd, prdata;
  logic pready, pslverr, rx_flow_active, tx_start_ok, mac_soft_rst, er;
  logic rx_dma_idle, tx_dma_idle;
  logic [7:0] rx_cells;
  mac_fifo_pkg::tx_fifo_state_t tx_state;
  int num_errors = 0, n_tests = 0;
  always #20 core_clk = ~core_clk;
  mac_fifo_ctrl dut_u (.*);
  dma_model pm_u (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask
  // outputs are registered, so look one and a half cycles (two falling edges) after the change
  task automatic step;
    repeat (2) @(negedge core_clk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #200000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    rdchk(12'h000, 32'h0002_0018);
    rdchk(12'h004, 32'h1844_0203);
    rdchk(12'h008, 32'h0000_0000);
    apb(1'b1, 12'h004, 32'hffff_ffff);
    rdchk(12'h004, 32'h1844_0203);
    // tx field written as 24, the top of the legal range
    apb(1'b1, 12'h000, 32'hffff_fff8);
    rdchk(12'h000, 32'h007f_0018);
    rdchk(12'h00c, 32'h0000_0000);
    chk(32'(er), 32'h1);
    apb(1'b1, 12'h000, 32'h0005_0003);
    rx_flow_en <= 1'b1;
    pm_u.load(8'h04, 8'h02, 1'b0);
    step();
    chk(32'(rx_flow_active), 32'h0);
    chk(32'(tx_start_ok), 32'h0);
    pm_u.load(8'h05, 8'h03, 1'b0);
    step();
    chk(32'(rx_flow_active), 32'h1);
    chk(32'(tx_start_ok), 32'h1);
    pm_u.load(8'h80, 8'h01, 1'b1);
    step();
    chk(32'(tx_start_ok), 32'h1);
    @(posedge core_clk);
    rx_flow_en <= 1'b0;
    step();
    chk(32'(rx_flow_active), 32'h0);
    pm_u.busy(1'b0, 1'b1);
    apb(1'b1, 12'h008, 32'h0000_0001);
    rdchk(12'h008, 32'h0000_0001);
    pm_u.busy(1'b0, 1'b0);
    for (int i = 0; i < 8 && mac_soft_rst !== 1'b1; i++) @(negedge core_clk);
    chk(32'(mac_soft_rst), 32'h1);
    rdchk(12'h008, 32'h0000_0000);
    rdchk(12'h000, 32'h0002_0018);
    // request with both engines already idle
    apb(1'b1, 12'h000, 32'h0005_0003);
    apb(1'b1, 12'h008, 32'h0000_0001);
    repeat (3) @(posedge core_clk);
    rdchk(12'h008, 32'h0000_0000);
    rdchk(12'h000, 32'h0002_0018);
    // hard reset while a request is pending drops it
    pm_u.load(8'h00, 8'h00, 1'b0);
    pm_u.busy(1'b0, 1'b1);
    apb(1'b1, 12'h008, 32'h0000_0001);
    @(posedge core_clk);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    pm_u.busy(1'b0, 1'b0);
    step();
    chk(32'(mac_soft_rst), 32'h0);
    rdchk(12'h008, 32'h0000_0000);
    report_and_stop();
  end
endmodule

// ### src/mac_fifo_ctrl.sv
// fifo thresholds, depth report and soft reset with apb registers
// Behaviour
// (RULE1) flow control fires at rx occupancy threshold
// (RULE2) rx threshold is seven bits 22:16
// (RULE3) tx starts after threshold cells present
// (RULE4) short packets start once fully buffered
// (RULE5) tx threshold is five bits 4:0
// (RULE6) software programs tx threshold 2 to 24
// (RULE7) tx depth 0x18 read-only bits 31:24
// (RULE8) rx depth 0x44 read-only bits 23:16
// (RULE9) writing bit zero requests soft reset
// (RULE10) reset waits until both dma idle
// (RULE11) bit reads one while reset pending
// (RULE12) reserved bits read zero, ignore writes
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps
module mac_fifo_ctrl (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_flow_en,
  input wire logic [mac_fifo_pkg::cell_w-1:0] rx_cells,
  input wire mac_fifo_pkg::tx_fifo_state_t tx_state,
  input wire logic rx_dma_idle,
  input wire logic tx_dma_idle,
  output logic rx_flow_active,
  output logic tx_start_ok,
  output logic mac_soft_rst
);
  ////////////////////////////////////////////////////////////////////////
  logic [mac_fifo_pkg::rx_flow_w-1:0] rx_flow_q;
  logic [mac_fifo_pkg::tx_start_w-1:0] tx_start_q;
  mac_fifo_pkg::soft_rst_state_t srst_q;
  mac_fifo_pkg::soft_rst_state_t srst_d;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic reset_pending;
  logic [31:0] rd_word;

  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign addr_ok = (paddr == mac_fifo_pkg::fifo_thresholds_addr) ||
    (paddr == mac_fifo_pkg::fifo_depth_config_addr) ||
    (paddr == mac_fifo_pkg::logic_reset_request_addr);
  assign pslverr = psel && penable && !addr_ok;

  ////////////////////////////////////////////////////////////////////////
  // threshold fields; soft reset restores them too
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_flow_q <= mac_fifo_pkg::rx_flow_reset; // RULE1
      tx_start_q <= mac_fifo_pkg::tx_start_reset;
    end else if (srst_q == mac_fifo_pkg::rst_fire) begin
      rx_flow_q <= mac_fifo_pkg::rx_flow_reset;
      tx_start_q <= mac_fifo_pkg::tx_start_reset;
    end else if (wr_en && paddr == mac_fifo_pkg::fifo_thresholds_addr) begin
      rx_flow_q <= pwdata[mac_fifo_pkg::rx_flow_lsb +: mac_fifo_pkg::rx_flow_w]; // RULE2
      // out-of-range values are stored as written; software keeps 2..24
      tx_start_q <= pwdata[mac_fifo_pkg::tx_start_lsb +: mac_fifo_pkg::tx_start_w]; // RULE5 RULE6
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    srst_d = srst_q;
    case (srst_q)
      mac_fifo_pkg::rst_idle: begin
        if (wr_en && paddr == mac_fifo_pkg::logic_reset_request_addr &&
            pwdata[mac_fifo_pkg::logic_reset_bit_pos]) begin
          srst_d = mac_fifo_pkg::rst_wait; // RULE9
        end
      end
      mac_fifo_pkg::rst_wait: begin
        // firing mid-transfer could hang the config bus
        if (rx_dma_idle && tx_dma_idle) begin
          srst_d = mac_fifo_pkg::rst_fire; // RULE10
        end
      end
      mac_fifo_pkg::rst_fire: begin
        // a request landing in the firing cycle is kept, not lost
        if (wr_en && paddr == mac_fifo_pkg::logic_reset_request_addr &&
            pwdata[mac_fifo_pkg::logic_reset_bit_pos]) begin
          srst_d = mac_fifo_pkg::rst_wait; // RULE9
        end else begin
          srst_d = mac_fifo_pkg::rst_idle;
        end
      end
      default: begin
        srst_d = mac_fifo_pkg::rst_idle;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      srst_q <= mac_fifo_pkg::rst_idle;
    end else begin
      srst_q <= srst_d;
    end
  end

  assign reset_pending = (srst_q != mac_fifo_pkg::rst_idle); // RULE11
  assign mac_soft_rst = (srst_q == mac_fifo_pkg::rst_fire);

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    rd_word = mac_fifo_pkg::word_zero; // RULE12
    case (paddr)
      mac_fifo_pkg::fifo_thresholds_addr: begin
        rd_word[mac_fifo_pkg::rx_flow_lsb +: mac_fifo_pkg::rx_flow_w] = rx_flow_q;
        rd_word[mac_fifo_pkg::tx_start_lsb +: mac_fifo_pkg::tx_start_w] = tx_start_q;
      end
      mac_fifo_pkg::fifo_depth_config_addr: begin
        rd_word[mac_fifo_pkg::tx_depth_lsb +: mac_fifo_pkg::cell_w] =
          mac_fifo_pkg::tx_fifo_size_cells; // RULE7
        rd_word[mac_fifo_pkg::rx_depth_lsb +: mac_fifo_pkg::cell_w] =
          mac_fifo_pkg::rx_fifo_size_cells; // RULE8
        rd_word[mac_fifo_pkg::addr_kind_lsb +: mac_fifo_pkg::cell_w] = mac_fifo_pkg::addr_kind;
        rd_word[0 +: mac_fifo_pkg::cell_w] = mac_fifo_pkg::mac_cfg_value;
      end
      mac_fifo_pkg::logic_reset_request_addr: begin
        rd_word[mac_fifo_pkg::logic_reset_bit_pos] = reset_pending; // RULE11
      end
      default: begin
        rd_word = mac_fifo_pkg::word_zero;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata <= mac_fifo_pkg::word_zero;
    end else if (psel && !penable && !pwrite) begin
      // captured in setup so it stands through the access phase
      prdata <= rd_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  rx_flow_trigger u_rx_flow (
    .core_clk(core_clk),
    .rst(rst),
    .flow_en(rx_flow_en),
    .rx_cells(rx_cells),
    .rx_flow_occupancy_level(rx_flow_q),
    .rx_flow_active(rx_flow_active)
  );

  tx_start_gate u_tx_start (
    .core_clk(core_clk),
    .rst(rst),
    .tx_state(tx_state),
    .tx_start_cell_level(tx_start_q),
    .tx_start_ok(tx_start_ok)
  );
endmodule

// ### src/mac_fifo_pkg.sv
// shared constants and carrier types for the fifo threshold and soft reset block
package mac_fifo_pkg;
  localparam logic [11:0] fifo_thresholds_addr = 12'h000;
  localparam logic [11:0] fifo_depth_config_addr = 12'h004;
  localparam logic [11:0] logic_reset_request_addr = 12'h008;
  localparam int rx_flow_lsb = 16;
  localparam int rx_flow_w = 7;
  localparam int tx_start_lsb = 0;
  localparam int tx_start_w = 5;
  localparam logic [6:0] rx_flow_reset = 7'h02;
  localparam logic [4:0] tx_start_reset = 5'h18;
  localparam logic [7:0] tx_fifo_size_cells = 8'h18;
  localparam logic [7:0] rx_fifo_size_cells = 8'h44;
  // address kind and configuration bytes of the depth word
  localparam logic [7:0] addr_kind = 8'h02;
  localparam logic [7:0] mac_cfg_value = 8'h03;
  localparam int tx_depth_lsb = 24;
  localparam int rx_depth_lsb = 16;
  localparam int addr_kind_lsb = 8;
  localparam int logic_reset_bit_pos = 0;
  localparam int cell_w = 8;
  localparam logic [31:0] word_zero = 32'h0000_0000;

  typedef struct packed {
    logic [cell_w-1:0] cells;
    logic pkt_done;
  } tx_fifo_state_t;

  typedef enum logic [2:0] {
    rst_idle = 3'b001,
    rst_wait = 3'b010,
    rst_fire = 3'b100
  } soft_rst_state_t;
endpackage

// ### src/rx_flow_trigger.sv
// receive flow control trigger from fifo occupancy
`timescale 1ns/1ps
module rx_flow_trigger (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic flow_en,
  input wire logic [mac_fifo_pkg::cell_w-1:0] rx_cells,
  input wire logic [mac_fifo_pkg::rx_flow_w-1:0] rx_flow_occupancy_level,
  output logic rx_flow_active
);
  logic hit;
  assign hit = flow_en &&
    (rx_cells >= {1'b0, rx_flow_occupancy_level}); // RULE1
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_flow_active <= 1'b0;
    end else begin
      rx_flow_active <= hit;
    end
  end
endmodule

// ### src/tx_start_gate.sv
// transmit start decision from cell threshold
`timescale 1ns/1ps
module tx_start_gate (
  input wire logic core_clk,
  input wire logic rst,
  input wire mac_fifo_pkg::tx_fifo_state_t tx_state,
  input wire logic [mac_fifo_pkg::tx_start_w-1:0] tx_start_cell_level,
  output logic tx_start_ok
);
  logic enough;
  assign enough = tx_state.cells >= {3'h0, tx_start_cell_level}; // RULE3
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_start_ok <= 1'b0;
    end else begin
      // short packets go as soon as they are whole
      tx_start_ok <= enough || tx_state.pkt_done; // RULE4
    end
  end
endmodule
